// *** verilog/dtm_pkg.sv ***
// Package: register map, field layout and encodings for the dual 8-bit timer
package dtm_pkg;
   // Register offsets (byte addresses on the plain register port)
   localparam logic [7:0] DTM_ADDR_CLKCTL  = 8'h00; // clock_control_reg: tick_speed_select
   localparam logic [7:0] DTM_ADDR_IRQFLG  = 8'h01; // timer_irq_flags
   localparam logic [7:0] DTM_ADDR_T0_BASE = 8'h10; // Timer 0 block
   localparam logic [7:0] DTM_ADDR_T1_BASE = 8'h20; // Timer 1 block
   // Offsets within a timer block
   localparam logic [3:0] DTM_OFS_CNT   = 4'h0; // counter_value_reg
   localparam logic [3:0] DTM_OFS_CTL   = 4'h1; // timer_control_reg
   localparam logic [3:0] DTM_OFS_CCTL0 = 4'h2; // channel_control_reg 0
   localparam logic [3:0] DTM_OFS_CC0   = 4'h3; // channel_value_reg 0
   localparam logic [3:0] DTM_OFS_CCTL1 = 4'h4; // channel_control_reg 1
   localparam logic [3:0] DTM_OFS_CC1   = 4'h5; // channel_value_reg 1
   // timer_control_reg fields
   localparam int DTM_CTL_DIV_LSB = 5;
   localparam int DTM_CTL_START   = 4;
   localparam int DTM_CTL_OVERFLOW_IRQ_MASK   = 3;
   localparam int DTM_CTL_CLR     = 2;
   localparam logic [7:0] DTM_CTL_RST = 8'h08;
   // channel_control_reg fields
   localparam int DTM_CCTL_IM      = 6;
   localparam int DTM_CCTL_CMP_LSB = 3;
   localparam int DTM_CCTL_MODE    = 2;
   localparam logic [7:0] DTM_CCTL_RST = 8'h40;
   // timer_irq_flags layout: {t1ch1,t1ch0,t0ch1,t0ch0,t1ovf,t0ovf} see flag index constants
   localparam int DTM_FLG_OVF0 = 0;
   localparam int DTM_FLG_OVF1 = 1;
   localparam int DTM_FLG_CH00 = 2; // timer 0 channel 0; channels of timer t at 2+2t+n
   localparam logic [7:0] DTM_BYTE_MIN = 8'h00;
   localparam logic [7:0] DTM_BYTE_MAX = 8'hFF;
   localparam logic [7:0] DTM_ZERO     = 8'h00;

   typedef enum logic [1:0] {
      DTM_MODE_FREE = 2'b00,
      DTM_MODE_DOWN = 2'b01,
      DTM_MODE_MOD  = 2'b10,
      DTM_MODE_UPDN = 2'b11
   } dtm_mode_e;

   typedef enum logic [2:0] {
      DTM_CMP_SET    = 3'b000,
      DTM_CMP_CLR    = 3'b001,
      DTM_CMP_TGL    = 3'b010,
      DTM_CMP_SETUP  = 3'b011,
      DTM_CMP_CLRUP  = 3'b100,
      DTM_CMP_SETMAX = 3'b101,
      DTM_CMP_CLRMIN = 3'b110,
      DTM_CMP_NONE   = 3'b111
   } dtm_cmp_e;

   localparam logic [1:0] DTM_CAP_RISE = 2'b01;
   localparam logic [1:0] DTM_CAP_FALL = 2'b10;
endpackage : dtm_pkg

// *** verilog/dtm_timer.sv ***
// One 8-bit timer with prescaler, counter and two capture/compare channels
`timescale 1ns/100ps
`default_nettype none
module dtm_timer
   import dtm_pkg::*;
(
   input  wire logic       clk_sys,     // System clock
   input  wire logic       rst,         // Synchronous reset, active high
   input  wire logic       tick,        // System tick enable pulse
   input  wire logic [7:0] ctl,         // timer_control_reg value
   input  wire logic       clr_pls,     // counter_clear write pulse
   input  wire logic [7:0] cctl0,       // Channel 0 control
   input  wire logic [7:0] cctl1,       // Channel 1 control
   input  wire logic [7:0] cc0_wr,      // Channel 0 value written by software
   input  wire logic [7:0] cc1_wr,      // Channel 1 value written by software
   input  wire logic [1:0] cap_in,      // Channel inputs, already synchronised
   output logic      [7:0] cnt_r,       // Counter
   output logic      [7:0] cap0_r,      // Channel 0 capture value
   output logic      [7:0] cap1_r,      // Channel 1 capture value
   output logic      [7:0] cmp0_r,      // Active channel 0 compare value
   output logic      [1:0] pin_r,       // Compare outputs
   output logic            ovf_evt,     // Terminal count event
   output logic      [1:0] ch_evt,      // Capture or compare event
   output logic      [1:0] dma_evt      // Compare event (DMA trigger)
);
   logic [6:0] pre_r;
   logic       down_r;
   logic [1:0] in_d_r;
   logic       run_r;

   // Prescaler: divide tick by 2^div
   wire [2:0] div      = ctl[DTM_CTL_DIV_LSB +: 3];
   wire [6:0] pre_mask = 7'(({7'b0, 1'b1} << div) - 8'h01);
   wire       start    = ctl[DTM_CTL_START];
   wire       edge_en  = start && tick && ((pre_r & pre_mask) == pre_mask);
   wire [1:0] mode     = ctl[1:0];
   wire       ld_dn    = start && !run_r && (mode == DTM_MODE_DOWN); // Down-mode load cycle
   wire       at_top   = (cnt_r == cmp0_r);
   wire       at_zero  = (cnt_r == DTM_ZERO);

   // Next count per mode
   logic [7:0] cnt_nxt;
   logic       down_nxt;
   always_comb begin
      cnt_nxt  = cnt_r;
      down_nxt = down_r;
      case (dtm_mode_e'(mode))
         DTM_MODE_FREE: cnt_nxt = 8'(cnt_r + 8'h01);
         DTM_MODE_DOWN: cnt_nxt = at_zero ? cnt_r : 8'(cnt_r - 8'h01);
         DTM_MODE_MOD:  cnt_nxt = at_top ? DTM_ZERO : 8'(cnt_r + 8'h01);
         DTM_MODE_UPDN: begin
            if (!down_r && at_top && !at_zero) begin
               down_nxt = 1'b1;
               cnt_nxt  = 8'(cnt_r - 8'h01);
            end else if (down_r && at_zero) begin
               down_nxt = 1'b0;
               cnt_nxt  = at_top ? cnt_r : 8'(cnt_r + 8'h01);
            end else if (down_r) begin
               cnt_nxt = 8'(cnt_r - 8'h01);
            end else begin
               cnt_nxt = at_top ? cnt_r : 8'(cnt_r + 8'h01);
            end
         end
         default: cnt_nxt = cnt_r;
      endcase
   end

   // Terminal count event per mode, only on an active edge
   wire ovf_hit = (mode == DTM_MODE_FREE) ? (cnt_r == DTM_BYTE_MAX) :
                  (mode == DTM_MODE_DOWN) ? at_zero :
                  (mode == DTM_MODE_MOD)  ? at_top  : (down_r && at_zero);
   // The load cycle still sees the old zero count, so it must not flag
   assign ovf_evt = edge_en && ovf_hit && !ld_dn;

   // Counter, prescaler, direction and down-mode load
   always_ff @(posedge clk_sys) begin
      run_r <= rst ? 1'b0 : start;
      if (rst) begin
         cnt_r  <= DTM_ZERO;
         pre_r  <= '0;
         down_r <= 1'b0;
      end else if (clr_pls) begin
         cnt_r  <= DTM_ZERO;
         pre_r  <= '0;
         down_r <= 1'b0;
      end else begin
         if (ld_dn) begin
            cnt_r <= cmp0_r;
         end else if (edge_en) begin
            cnt_r  <= cnt_nxt;
            down_r <= down_nxt;
         end
         if (start && tick) pre_r <= 7'(pre_r + 7'h01);
      end
   end

   // Compare value: channel 0 buffered until counter is zero, channel 1 direct
   always_ff @(posedge clk_sys) begin
      if (rst) cmp0_r <= DTM_ZERO;
      else if (at_zero) cmp0_r <= cc0_wr;
   end

   // Channel logic for both channels
   wire [7:0] cctl [2];
   wire [7:0] cval [2];
   assign cctl[0] = cctl0;
   assign cctl[1] = cctl1;
   assign cval[0] = cmp0_r;
   assign cval[1] = cc1_wr;

   always_ff @(posedge clk_sys) begin
      in_d_r <= rst ? 2'b00 : cap_in;
   end

   for (genvar n = 0; n < 2; n++) begin : g_ch
      wire       cmp_md = cctl[n][DTM_CCTL_MODE];
      wire [2:0] cmpsel = cctl[n][DTM_CCTL_CMP_LSB +: 3];
      wire [1:0] capsel = cctl[n][1:0];
      wire rise = cap_in[n] && !in_d_r[n];
      wire fall = !cap_in[n] && in_d_r[n];
      wire cap_hit = start && !cmp_md &&
                     ((capsel[0] && rise) || (capsel[1] && fall));
      wire cmp_hit = start && cmp_md && edge_en && (cnt_r == cval[n]);
      wire zer_hit = start && cmp_md && edge_en && at_zero;
      wire max_hit = start && cmp_md && edge_en && (cnt_r == DTM_BYTE_MAX);
      assign ch_evt[n]  = cap_hit || cmp_hit;
      assign dma_evt[n] = cmp_hit;
      // Output pin registered so its edges are glitch-free
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            pin_r[n] <= 1'b0;
         end else if (cmp_hit) begin
            case (dtm_cmp_e'(cmpsel))
               DTM_CMP_SET, DTM_CMP_SETMAX: pin_r[n] <= 1'b1;
               DTM_CMP_CLR, DTM_CMP_CLRMIN: pin_r[n] <= 1'b0;
               DTM_CMP_TGL:   pin_r[n] <= !pin_r[n];
               DTM_CMP_SETUP: pin_r[n] <= !down_r;
               DTM_CMP_CLRUP: pin_r[n] <= down_r;
               default:       pin_r[n] <= pin_r[n];
            endcase
         end else if (zer_hit && cmpsel == DTM_CMP_SETUP) begin
            pin_r[n] <= 1'b0;
         end else if (zer_hit && (cmpsel == DTM_CMP_CLRUP || cmpsel == DTM_CMP_CLRMIN)) begin
            pin_r[n] <= 1'b1;
         end else if (max_hit && cmpsel == DTM_CMP_SETMAX) begin
            pin_r[n] <= 1'b0;
         end
      end
   end

   // Capture registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cap0_r <= DTM_ZERO;
         cap1_r <= DTM_ZERO;
      end else begin
         if (g_ch[0].cap_hit) cap0_r <= cnt_r;
         if (g_ch[1].cap_hit) cap1_r <= cnt_r;
      end
   end
endmodule : dtm_timer
`default_nettype wire

// *** verilog/dtm_top.sv ***
// Top: dual 8-bit timer with register port, flags, interrupts and DMA triggers
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Two timers, 8-bit counter, two channels
// - Count only on prescaled tick edges
// - Start bit runs, clearing freezes counter
// - Free-running counts 0x00 to 0xFF, wraps
// - Overflow flag at 0xFF, masked interrupt
// - Down mode loads channel 0, counts down
// - Modulo counts up to channel 0 value
// - Up/down counts up then down
// - Counter clear zeroes count, direction up
// - Selected input edge captures the counter
// - Inputs synchronised; pulses exceed one clock
// - Capture sets channel flag, masked interrupt
// - Compare match sets, clears, toggles pin
// - Channel 0 value latched at zero
// - Compare sets channel flag, masked interrupt
// - One interrupt line per timer
// - One flag register covers all events
// - Flag must clear; unmasking pending interrupts
// - DMA trigger pulse per channel compare
// - Mode codes: free, down, modulo, up/down
// - Prescale codes divide one to 128
// - Compare output mode encodings
// - Capture edge select encodings
module dtm_top
   import dtm_pkg::*;
#(
   parameter int NUM_TIMERS = 2  // Fixed at two timers
)(
   input  wire logic       clk_sys,   // System clock, 10 MHz
   input  wire logic       rst,       // Synchronous reset, active high
   input  wire logic [7:0] reg_addr,  // Register address
   input  wire logic [7:0] reg_wdata, // Write data
   input  wire logic       reg_wr,    // Write strobe
   input  wire logic       reg_rd,    // Read strobe
   output logic      [7:0] reg_rdata, // Read data, cycle after strobe
   input  wire logic [1:0] t0_in,     // Timer 0 channel inputs
   input  wire logic [1:0] t1_in,     // Timer 1 channel inputs
   output logic      [1:0] t0_out,    // Timer 0 compare outputs
   output logic      [1:0] t1_out,    // Timer 1 compare outputs
   output logic            t0_irq,    // Timer 0 interrupt request
   output logic            t1_irq,    // Timer 1 interrupt request
   output logic      [1:0] t0_dma,    // Timer 0 DMA trigger pulses
   output logic      [1:0] t1_dma     // Timer 1 DMA trigger pulses
);
   if (NUM_TIMERS != 2) begin : g_chk
      $error("dtm_top supports exactly two timers");
   end

   // Control registers
   logic [2:0] tick_speed_select_r;
   logic [7:0] ctl_r   [2];
   logic [7:0] cctl0_r [2];
   logic [7:0] cctl1_r [2];
   logic [7:0] cc0_r   [2];
   logic [7:0] cc1_r   [2];
   logic [5:0] flags_r;
   logic [6:0] tdiv_r;
   logic       tick_r;
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;

   // Per-timer results
   wire [7:0] cnt  [2];
   wire [7:0] cap0 [2];
   wire [7:0] cap1 [2];
   wire [7:0] cmp0 [2];
   wire [1:0] pin  [2];
   wire       ovf  [2];
   wire [1:0] chev [2];
   wire [1:0] dmav [2];

   // Address decoding
   wire       in_t0   = (reg_addr[7:4] == DTM_ADDR_T0_BASE[7:4]);
   wire       in_t1   = (reg_addr[7:4] == DTM_ADDR_T1_BASE[7:4]);
   wire [3:0] ofs     = reg_addr[3:0];
   wire       wr_clk  = reg_wr && (reg_addr == DTM_ADDR_CLKCTL);
   wire       wr_flg  = reg_wr && (reg_addr == DTM_ADDR_IRQFLG);
   wire [1:0] wr_tsel = {reg_wr && in_t1, reg_wr && in_t0};

   // Tick generator: tick_speed_select divides the system clock by 2^n
   wire [6:0] tmask = 7'(({7'b0, 1'b1} << tick_speed_select_r) - 8'h01);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tdiv_r <= '0;
         tick_r <= 1'b0;
      end else begin
         tdiv_r <= 7'(tdiv_r + 7'h01);
         tick_r <= ((tdiv_r & tmask) == tmask);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) tick_speed_select_r <= '0;
      else if (wr_clk) tick_speed_select_r <= reg_wdata[2:0];
   end

   // Two-flop synchronisers on channel inputs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {t1_in, t0_in};
         sync2_r <= sync1_r;
      end
   end

   // Per-timer registers and timer instances
   for (genvar t = 0; t < 2; t++) begin : g_tmr
      wire wr = wr_tsel[t];
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            ctl_r[t]   <= DTM_CTL_RST;
            cctl0_r[t] <= DTM_CCTL_RST;
            cctl1_r[t] <= DTM_CCTL_RST;
            cc0_r[t]   <= DTM_ZERO;
            cc1_r[t]   <= DTM_ZERO;
         end else if (wr) begin
            if (ofs == DTM_OFS_CTL) begin
               ctl_r[t] <= reg_wdata & ~(8'h01 << DTM_CTL_CLR);
            end else if (ofs == DTM_OFS_CCTL0) begin
               cctl0_r[t] <= reg_wdata & 8'h7F;
            end else if (ofs == DTM_OFS_CC0) begin
               cc0_r[t] <= reg_wdata;
            end else if (ofs == DTM_OFS_CCTL1) begin
               cctl1_r[t] <= reg_wdata & 8'h7F;
            end else if (ofs == DTM_OFS_CC1) begin
               cc1_r[t] <= reg_wdata;
            end
         end
      end
      wire clr_pls = wr && (ofs == DTM_OFS_CTL) && reg_wdata[DTM_CTL_CLR];

      dtm_timer u_timer (
         .clk_sys (clk_sys),
         .rst     (rst),
         .tick    (tick_r),
         .ctl     (ctl_r[t]),
         .clr_pls (clr_pls),
         .cctl0   (cctl0_r[t]),
         .cctl1   (cctl1_r[t]),
         .cc0_wr  (cc0_r[t]),
         .cc1_wr  (cc1_r[t]),
         .cap_in  (sync2_r[2*t +: 2]),
         .cnt_r   (cnt[t]),
         .cap0_r  (cap0[t]),
         .cap1_r  (cap1[t]),
         .cmp0_r  (cmp0[t]),
         .pin_r   (pin[t]),
         .ovf_evt (ovf[t]),
         .ch_evt  (chev[t]),
         .dma_evt (dmav[t])
      );
   end

   // Flag set vector: overflow bits then channel bits, set wins over clear
   wire [5:0] flag_set = {chev[1], chev[0], ovf[1], ovf[0]};
   wire [5:0] flag_clr = wr_flg ? ~reg_wdata[5:0] : 6'h00;
   wire [5:0] flags_nxt = (flags_r & ~flag_clr) | flag_set;
   always_ff @(posedge clk_sys) begin
      if (rst) flags_r <= '0;
      else flags_r <= flags_nxt;
   end

   // Interrupt level: any flag with its mask set; unmasking a pending flag requests at once
   wire [1:0] irq_nxt;
   for (genvar t = 0; t < 2; t++) begin : g_irq
      wire ovf_req = flags_nxt[DTM_FLG_OVF0 + t] && ctl_r[t][DTM_CTL_OVERFLOW_IRQ_MASK];
      wire c0_req  = flags_nxt[DTM_FLG_CH00 + 2*t] && cctl0_r[t][DTM_CCTL_IM];
      wire c1_req  = flags_nxt[DTM_FLG_CH00 + 2*t + 1] && cctl1_r[t][DTM_CCTL_IM];
      assign irq_nxt[t] = ovf_req || c0_req || c1_req;
   end

   // Registered outputs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         t0_out <= '0;
         t1_out <= '0;
         t0_irq <= 1'b0;
         t1_irq <= 1'b0;
         t0_dma <= '0;
         t1_dma <= '0;
      end else begin
         t0_out <= pin[0];
         t1_out <= pin[1];
         t0_irq <= irq_nxt[0];
         t1_irq <= irq_nxt[1];
         t0_dma <= dmav[0];
         t1_dma <= dmav[1];
      end
   end

   // Read mux: capture value in capture mode, written value in compare mode
   wire       rt = in_t1;
   wire [7:0] v0 = cctl0_r[rt][DTM_CCTL_MODE] ? cc0_r[rt] : cap0[rt];
   wire [7:0] v1 = cctl1_r[rt][DTM_CCTL_MODE] ? cc1_r[rt] : cap1[rt];
   wire [7:0] tsel_rd = (ofs == DTM_OFS_CNT)   ? cnt[rt] :
                        (ofs == DTM_OFS_CTL)   ? ctl_r[rt] :
                        (ofs == DTM_OFS_CCTL0) ? cctl0_r[rt] :
                        (ofs == DTM_OFS_CC0)   ? v0 :
                        (ofs == DTM_OFS_CCTL1) ? cctl1_r[rt] :
                        (ofs == DTM_OFS_CC1)   ? v1 : DTM_ZERO;
   wire [7:0] rd_mux = (reg_addr == DTM_ADDR_CLKCTL) ? {5'b0, tick_speed_select_r} :
                       (reg_addr == DTM_ADDR_IRQFLG) ? {2'b0, flags_r} :
                       (in_t0 || in_t1)              ? tsel_rd : DTM_ZERO;

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) reg_rdata <= DTM_ZERO;
      else reg_rdata <= reg_rd ? rd_mux : DTM_ZERO;
   end
endmodule : dtm_top
`default_nettype wire

// *** tb/dtm_props.sv ***
// Checker: port-level properties of the dual timer
`timescale 1ns/100ps
`default_nettype none
module dtm_props #(
   parameter int NUM_TIMERS = 2 // Timer count
)(
   input wire logic       clk_sys,   // Clock
   input wire logic       rst,       // Reset
   input wire logic [7:0] reg_addr,  // Address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic       reg_wr,    // Write strobe
   input wire logic       reg_rd,    // Read strobe
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic       t0_irq,    // Timer 0 request
   input wire logic       t1_irq,    // Timer 1 request
   input wire logic [1:0] t0_dma,    // Timer 0 triggers
   input wire logic [1:0] t1_dma     // Timer 1 triggers
);
   logic       run_r;  // Shadow of timer 0 start bit
   logic [2:0] m_r;    // Shadow of timer 0 masks
   logic [2:0] run_sh; // Start history
   logic [2:0] msk_sh; // Any-mask history
   wire        stp    = run_sh == 3'h0;
   wire        idle_m = msk_sh == 3'h0;
   // Shadow of software writes, so stopped and masked spans are known
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         run_r <= 1'b0;
         m_r   <= 3'h7;
      end else if (reg_wr && reg_addr == 8'h11) begin
         run_r  <= reg_wdata[4];
         m_r[0] <= reg_wdata[3];
      end else if (reg_wr && reg_addr == 8'h12) begin
         m_r[1] <= reg_wdata[6];
      end else if (reg_wr && reg_addr == 8'h14) begin
         m_r[2] <= reg_wdata[6];
      end
   end
   // Three cycles of history cover the register hops inside the design
   always_ff @(posedge clk_sys) begin
      run_sh <= rst ? 3'h7 : {run_sh[1:0], run_r};
      msk_sh <= rst ? 3'h7 : {msk_sh[1:0], |m_r};
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_reset_quiet: assert property (
      $fell(rst) |-> !t0_irq && !t1_irq && t0_dma == 2'h0 && t1_dma == 2'h0 && reg_rdata == 8'h00)
      else $error("Outputs active after reset");
   chk_clr_reads_zero: assert property (
      reg_rd && (reg_addr == 8'h11 || reg_addr == 8'h21) |=> !reg_rdata[2])
      else $error("Clear bit read back as one");
   chk_cnt_frozen: assert property (
      (reg_rd && reg_addr == 8'h10 && stp) ##1 !reg_wr ##1 (reg_rd && reg_addr == 8'h10 && stp)
      |=> reg_rdata == $past(reg_rdata, 2))
      else $error("Counter moved while stopped");
   chk_stop_no_dma: assert property (stp |-> t0_dma == 2'h0)
      else $error("Compare event while stopped");
   chk_mask_quiet: assert property (idle_m |-> !t0_irq)
      else $error("Request with all masks off");
   chk_dma0_pulse: assert property (t0_dma[0] |=> !t0_dma[0])
      else $error("Channel 0 trigger longer than a cycle");
   chk_dma1_pulse: assert property (t0_dma[1] |=> !t0_dma[1])
      else $error("Channel 1 trigger longer than a cycle");
   chk_flags_width: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata[7:6] == 2'h0)
      else $error("Unused flag bits set");
   cov_dma: cover property (t0_dma[1]);
   cov_irq0: cover property (t0_irq && !idle_m);
   cov_irq1: cover property (t1_irq);
endmodule : dtm_props

bind dtm_top dtm_props #(.NUM_TIMERS(NUM_TIMERS)) u_props (
   .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t0_irq(t0_irq), .t1_irq(t1_irq), .t0_dma(t0_dma),
   .t1_dma(t1_dma));
`default_nettype wire

// *** tb/dtm_pin_model.sv ***
// External pin model: drives the channel inputs with held pulses
`timescale 1ns/100ps
`default_nettype none
module dtm_pin_model #(
   parameter int HOLD = 3 // Pulse length in clocks
)(
   input  wire logic       clk_sys, // Clock
   input  wire logic [3:0] req,     // Pulse request per line
   output var  logic [3:0] pins     // {t1_in, t0_in}
);
   int cnt [4] = '{default: 0};
   // A pulse stands several clocks, longer than one clock period
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < 4; i++) begin
         if (req[i]) cnt[i] <= HOLD;
         else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
      end
   end
   // Line is high while its pulse lasts
   always_comb begin
      for (int i = 0; i < 4; i++) pins[i] = cnt[i] > 0;
   end
endmodule : dtm_pin_model
`default_nettype wire

// *** tb/testbench.sv ***
// Testbench: register-level scenarios for the dual timer
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import dtm_pkg::*;
   logic       clk_sys = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [3:0] req = 4'h0;
   logic [7:0] reg_rdata, v, w, b, mx;
   logic [3:0] pins;
   logic [1:0] t0_out, t1_out, t0_dma, t1_dma;
   logic       t0_irq, t1_irq, prv;
   logic [5:0] pre [3] = '{6'h03, 6'h0A, 6'h18};
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n_dma, n_tgl, dn1, wrap, k;
   always #50 clk_sys = ~clk_sys;
   dtm_top #(.NUM_TIMERS(2)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t0_in(pins[1:0]), .t1_in(pins[3:2]), .t0_out(t0_out),
      .t1_out(t1_out), .t0_irq(t0_irq), .t1_irq(t1_irq), .t0_dma(t0_dma), .t1_dma(t1_dma));
   dtm_pin_model pin_u (.clk_sys(clk_sys), .req(req), .pins(pins));
   // Event counters for the compare output; a hang is cut short here too
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (t0_dma[1] === 1'b1) n_dma++;
      if (t0_out[1] !== prv) n_tgl++;
      prv <= t0_out[1];
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask : rdc
   task automatic wait_irq(input logic e0, input logic e1);
      repeat (2) @(posedge clk_sys);
      #1 chk("irq pair", {6'h00, e1, e0}, {6'h00, t1_irq, t0_irq});
   endtask : wait_irq
   task automatic pulse(input logic [3:0] m);
      @(posedge clk_sys);
      req <= m;
      @(posedge clk_sys);
      req <= 4'h0;
   endtask : pulse
   // Samples every two cycles at a divided rate, so steps are at most one
   task automatic sweep(input logic [7:0] lim);
      logic [7:0] p;
      mx = 8'h00;
      dn1 = 0;
      wrap = 0;
      p = 8'h00;
      repeat (40) begin
         rd(8'h10, v);
         if (v > mx) mx = v;
         if (v + 8'h01 == p) dn1++;
         if (v + 8'h01 < p) wrap++;
         p = v;
      end
      chk("peak", lim, mx);
   endtask : sweep
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      for (int t = 1; t <= 2; t++) begin
         b = 8'(16 * t);
         rdc(b, 8'h00);
         rdc(b + 8'h01, DTM_CTL_RST);
         rdc(b + 8'h02, DTM_CCTL_RST);
         rdc(b + 8'h04, DTM_CCTL_RST);
      end
      rdc(DTM_ADDR_IRQFLG, 8'h00);
      rdc(8'h3F, 8'h00);
      // Free-running overflow, freeze, pending flag unmasked later
      wr(8'h12, 8'h00);
      wr(8'h14, 8'h00);
      wr(8'h11, 8'h14);
      repeat (300) @(posedge clk_sys);
      wr(8'h11, 8'h00);
      rdc(8'h01, 8'h01);
      wait_irq(1'b0, 1'b0);
      rd(8'h10, v);
      rd(8'h10, w);
      chk("frozen count", v, w);
      wr(8'h11, 8'h08);
      wait_irq(1'b1, 1'b0);
      wr(8'h01, 8'h00);
      wait_irq(1'b0, 1'b0);
      wr(8'h11, 8'h04);
      rdc(8'h10, 8'h00);
      rdc(8'h11, 8'h00);
      // Each pair of tick speed and divider makes one edge per eight clocks
      foreach (pre[i]) begin
         wr(DTM_ADDR_CLKCTL, {5'h00, pre[i][5:3]});
         wr(8'h11, {pre[i][2:0], 5'h14});
         repeat (80) @(posedge clk_sys);
         wr(8'h11, 8'h00);
         rd(8'h10, v);
         chk("prescaled count", 8'h01, {7'h00, v >= 8'h09 && v <= 8'h0B});
      end
      wr(DTM_ADDR_CLKCTL, 8'h00);
      // Modulo then up/down, channel 0 value latched while the count is zero
      wr(8'h13, 8'h05);
      wr(8'h11, 8'h44);
      wr(8'h11, 8'h52);
      sweep(8'h05);
      chk("modulo wrap", 8'h01, {7'h00, wrap > 0});
      rd(8'h01, v);
      chk("modulo flag", 8'h01, {7'h00, v[0]});
      wr(8'h11, 8'h40);
      wr(8'h13, 8'h04);
      wr(8'h11, 8'h44);
      wr(8'h11, 8'h53);
      sweep(8'h04);
      chk("turn down", 8'h01, {7'h00, dn1 > 0 && wrap == 0});
      wr(8'h11, 8'h57);
      rd(8'h10, v);
      rd(8'h10, w);
      chk("up after clear", 8'h01, {7'h00, w >= v});
      // Down mode from the channel 0 value
      wr(8'h11, 8'h00);
      wr(8'h13, 8'h10);
      wr(8'h11, 8'h04);
      wr(8'h01, 8'h00);
      wr(8'h11, 8'h11);
      rdc(8'h01, 8'h00);
      rd(8'h10, v);
      chk("counting down", 8'h01, {7'h00, v > 8'h00 && v < 8'h10});
      repeat (30) @(posedge clk_sys);
      rd(8'h01, w);
      chk("down flag", 8'h01, {7'h00, w[0]});
      rdc(8'h10, 8'h00);
      // Capture on each edge code, alternating timers
      wr(8'h11, 8'h14);
      wr(8'h21, 8'h14);
      for (int e = 0; e < 4; e++) begin
         b = e[0] ? 8'h20 : 8'h10;
         k = e[0] ? 5 : 3;
         wr(b + 8'h04, {6'h10, e[1:0]});
         wr(8'h01, 8'h00);
         rd(b, v);
         pulse(e[0] ? 4'h8 : 4'h2);
         repeat (8) @(posedge clk_sys);
         #1 chk("irq", {7'h00, e != 0}, {7'h00, e[0] ? t1_irq : t0_irq});
         rd(8'h01, w);
         chk("capture flag", {7'h00, e != 0}, {7'h00, w[k]});
         rd(b + 8'h05, w);
         if (e != 0) chk("capture value", 8'h01, {7'h00, 8'(w - v) <= 8'h0C});
         wr(8'h01, 8'h00);
         wait_irq(1'b0, 1'b0);
      end
      // Compare toggle on channel 1, then clear and set codes
      wr(8'h11, 8'h00);
      wr(8'h15, 8'h20);
      wr(8'h14, 8'h54);
      wr(8'h12, 8'h14);
      wr(8'h01, 8'h00);
      n_dma = 0;
      n_tgl = 0;
      wr(8'h11, 8'h14);
      repeat (600) @(posedge clk_sys);
      #1 chk("dma pulses", 8'h03, 8'(n_dma));
      chk("pin toggles", 8'h03, 8'(n_tgl));
      rd(8'h01, v);
      chk("compare flag", 8'h01, {7'h00, v[3]});
      chk("ch0 flag", 8'h01, {7'h00, v[2]});
      chk("ch0 toggles", 8'h01, {7'h00, t0_out[0]});
      wait_irq(1'b1, 1'b0);
      wr(8'h14, 8'h4C);
      repeat (260) @(posedge clk_sys);
      #1 chk("clear code", 8'h00, {7'h00, t0_out[1]});
      wr(8'h14, 8'h44);
      repeat (260) @(posedge clk_sys);
      #1 chk("set code", 8'h01, {7'h00, t0_out[1]});
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
